// ===== testbench.sv
// self-checking testbench of the timer mode engine
`timescale 1ns/1ps
`include "tmr_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, wa, wa_oe, wb, wb_oe, err_q, w0;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  tmr_mode_engine tmr_mode_engine_i (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_wave_pin_a(wa), .o_wave_pin_a_oe(wa_oe), .o_wave_pin_b(wb),
    .o_wave_pin_b_oe(wb_oe));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1); // no fixed wait, timeout guards it
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK("read data", e, rd_q)
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] p,
      input logic [1:0] a, input logic [1:0] b);
    return {18'h0, 2'h3, b, a, 1'h0, p, m};
  endfunction
  // run at full rate for a while, then stop so the count can be read calmly
  task automatic run(input logic [3:0] m, input logic [1:0] a, input logic [1:0] b, int n);
    wr(`TMR_OFF_CTRL, ctl(m, 3'h1, a, b));
    repeat (n) @(posedge clk);
    wr(`TMR_OFF_CTRL, ctl(m, 3'h0, a, b));
    apb(1'h0, `TMR_OFF_COUNT, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdc(12'(4 * i), 32'h0);
    end
    rdc(12'h020, 32'h0);
    `CHK("unmapped error", 1'h1, err_q)
  endtask
  task automatic t_normal;
    logic [31:0] st [2] = '{32'h0000_FFF0, 32'h0000_FFFE};
    for (int i = 0; i < 2; i++) begin
      wr(`TMR_OFF_COUNT, st[i]);
      run(`TMR_WGM_NORMAL, 2'h0, 2'h0, 4);
      `CHK("count window", 1'h1, (rd_q > st[i]) ^ i[0])
      // passing zero also meets both compare values, still zero from reset
      rdc(`TMR_OFF_FLAGS, i[0] ? 32'h7 : 32'h0);
    end
    run(`TMR_WGM_NORMAL, 2'h0, 2'h0, 4);
    rdc(`TMR_OFF_FLAGS, 32'h7);
    wr(`TMR_OFF_FLAGS, 32'h1);
    rdc(`TMR_OFF_FLAGS, 32'h6);
  endtask
  task automatic t_force;
    logic [1:0] act [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
    logic ex [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
    // start from clean flags so a stray set by a force would show
    wr(`TMR_OFF_FLAGS, 32'hF);
    for (int i = 0; i < 5; i++) begin
      wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_NORMAL, 3'h0, act[i], act[i]));
      wr(`TMR_OFF_FORCE, 32'h3);
      @(negedge clk);
      `CHK("forced waves", {2{ex[i]}}, {wb, wa})
    end
    rdc(`TMR_OFF_FLAGS, 32'h0);
    wr(`TMR_OFF_CTRL, 32'h0);
    @(negedge clk);
    `CHK("pin enables", 2'h0, {wb_oe, wa_oe})
  endtask
  task automatic t_ctc;
    logic [3:0] md [2] = '{`TMR_WGM_CTC_A, `TMR_WGM_CTC_CAP};
    logic [31:0] fl [2] = '{32'h6, 32'hE};
    for (int i = 0; i < 2; i++) begin
      wr(`TMR_OFF_MATCH_A, 32'h3);
      wr(`TMR_OFF_CAPTOP, 32'h5);
      wr(`TMR_OFF_COUNT, 32'h0);
      wr(`TMR_OFF_FLAGS, 32'hF);
      run(md[i], 2'h0, 2'h0, 20);
      `CHK("ctc count", 1'h1, rd_q <= (i ? 32'h5 : 32'h3))
      rdc(`TMR_OFF_FLAGS, fl[i]);
    end
    // top written below the count: no clear until the count wraps
    wr(`TMR_OFF_MATCH_A, 32'h10);
    wr(`TMR_OFF_COUNT, 32'h20);
    wr(`TMR_OFF_FLAGS, 32'hF);
    run(`TMR_WGM_CTC_A, 2'h0, 2'h0, 6);
    `CHK("missed top", 1'h1, rd_q > 32'h20)
    rdc(`TMR_OFF_FLAGS, 32'h0);
    // start at max so the blocked first match does not lose a period
    wr(`TMR_OFF_MATCH_A, 32'h0);
    wr(`TMR_OFF_COUNT, 32'hFFFF);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_CTC_A, 3'h1, 2'h1, 2'h0));
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      w0 = wa;
      @(negedge clk);
      `CHK("half rate toggle", ~w0, wa)
    end
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_CTC_A, 3'h0, 2'h1, 2'h0));
    // wrap from max at the blocked first tick, then matches on a and b at zero
    rdc(`TMR_OFF_FLAGS, 32'h7);
  endtask
  task automatic t_pwm;
    int hi = 0;
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM8, 3'h0, 2'h0, 2'h0));
    wr(`TMR_OFF_MATCH_A, 32'h0000_1234);
    rdc(`TMR_OFF_MATCH_A, 32'h0000_0034);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM_CAP, 3'h0, 2'h3, 2'h2));
    wr(`TMR_OFF_CAPTOP, 32'h7);
    wr(`TMR_OFF_MATCH_A, 32'h3);
    wr(`TMR_OFF_MATCH_B, 32'h3);
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_FLAGS, 32'hF);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM_CAP, 3'h1, 2'h3, 2'h2));
    repeat (20) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      hi += int'(wb);
      `CHK("inverted pair", ~wb, wa)
    end
    `CHK("pwm duty", 1'h1, hi > 0 && hi < 8)
    run(`TMR_WGM_FPWM_CAP, 2'h3, 2'h2, 1);
    `CHK("pwm count", 1'h1, rd_q <= 32'h7)
    apb(1'h0, `TMR_OFF_FLAGS, 32'h0);
    `CHK("top flags", 32'h9, rd_q & 32'h9)
  endtask
  // mode 15 toggle; buffered top 2 replaces the active 3 at the first top
  task automatic t_fast_toggle;
    int tg = 0;
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM_A, 3'h0, 2'h1, 2'h0));
    wr(`TMR_OFF_MATCH_A, 32'h2);
    wr(`TMR_OFF_MATCH_B, 32'h2);
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM_A, 3'h1, 2'h1, 2'h0));
    repeat (10) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      w0 = wa;
      @(negedge clk);
      tg += int'(wa != w0);
    end
    `CHK("toggles in twelve ticks", 32'h4, tg)
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_FPWM_A, 3'h0, 2'h1, 2'h0));
  endtask
  // divide by 8: 41 running edges hold exactly five ticks
  task automatic t_prescale;
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_NORMAL, 3'h2, 2'h0, 2'h0));
    repeat (38) @(posedge clk);
    wr(`TMR_OFF_CTRL, ctl(`TMR_WGM_NORMAL, 3'h0, 2'h0, 2'h0));
    rdc(`TMR_OFF_COUNT, 32'h5);
  endtask
  // ----------------------------------------------------------------
  // clock, timeout, sequence and verdict
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_normal();
    t_force();
    t_ctc();
    t_pwm();
    t_fast_toggle();
    t_prescale();
    print_verdict();
  end
endmodule

// ===== tmr_cfg.svh
// register offsets, field positions, reset values and mode codes of the timer mode engine
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMR_OFF_CTRL 12'h000
`define TMR_OFF_COUNT 12'h004
`define TMR_OFF_MATCH_A 12'h008
`define TMR_OFF_MATCH_B 12'h00C
`define TMR_OFF_CAPTOP 12'h010
`define TMR_OFF_FLAGS 12'h014
`define TMR_OFF_FORCE 12'h018
`define TMR_OFF_STATUS 12'h01C

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define TMR_CTRL_WGM_LSB 0
`define TMR_CTRL_PRE_LSB 4
`define TMR_CTRL_ACT_A_LSB 8
`define TMR_CTRL_ACT_B_LSB 10
`define TMR_CTRL_DIR_A_BIT 12
`define TMR_CTRL_DIR_B_BIT 13

// flag bit positions
`define TMR_FLAG_WRAP_BIT 0
`define TMR_FLAG_MA_BIT 1
`define TMR_FLAG_MB_BIT 2
`define TMR_FLAG_CAP_BIT 3

// ----------------------------------------------------------------
// counts and values
// ----------------------------------------------------------------
`define TMR_MAX 16'hFFFF
`define TMR_BOTTOM 16'h0000
`define TMR_TOP_8 16'h00FF
`define TMR_TOP_9 16'h01FF
`define TMR_TOP_10 16'h03FF
`define TMR_MIN_TOP 16'h0003
`define TMR_CTRL_RST 32'h0000_0000

// waveform mode codes
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_FPWM8 4'h5
`define TMR_WGM_FPWM9 4'h6
`define TMR_WGM_FPWM10 4'h7
`define TMR_WGM_CTC_A 4'h4
`define TMR_WGM_CTC_CAP 4'hC
`define TMR_WGM_FPWM_CAP 4'hE
`define TMR_WGM_FPWM_A 4'hF

// prescaler divide factors
`define TMR_DIV_8 11'h008
`define TMR_DIV_64 11'h040
`define TMR_DIV_256 11'h100
`define TMR_DIV_1024 11'h400

`endif

// ===== tmr_mode_engine.sv
// 16-bit timer mode engine with two compare channels and an apb register port
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

// Notes on behaviour
// - mode comes from wave_gen_sel only; action never alters counting
// - non-pwm: out_action_sel picks set, clear or toggle on match
// - mode 0 counts up only, no clear, wraps 0xFFFF to 0x0000
// - normal mode: wrap_flag set in the cycle the count becomes zero
// - counter only sets wrap_flag; software clears it
// - ctc clears counter on match with match_value_a (4) or capture (12)
// - ctc top unbuffered; top below count runs to 0xFFFF and wraps
// - ctc sets match_flag_a or capture_flag at top, per top source
// - ctc with action 1 toggles output a on every match
// - ctc: wrap_flag set when counter passes max to 0x0000
// - modes 5,6,7,14,15 count bottom to top then restart at bottom
// - fast pwm top fixed 0xFF/0x1FF/0x3FF, capture or match a; clear after top
// - fast pwm sets wrap_flag at top, plus top register's flag same cycle
// - fixed top masks unused upper bits of compare writes to zero
// - capture_top_value takes effect as top at once, no buffering
// - fast pwm match_value_a buffered, loaded at top with clear and wrap
// - fast pwm action 2 clears on match, sets at bottom; 3 inverse
// - compare 0 gives one-tick spike; compare equal top gives steady level
// - fast pwm action 1 toggles output a only in mode 15
// - waveform reaches its pin only when its direction bit is output
// - register top supports 2-bit to 16-bit resolutions
// - timer tick is clock divided by 1, 8, 64, 256 or 1024
// - counter write blocks compare matches in the next timer cycle
// - non-pwm force strobe acts like a match without flag or clear
// - reset clears the internal waveform registers to zero
module tmr_mode_engine
  import tmr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_wave_pin_a,
  output logic o_wave_pin_a_oe,
  output logic o_wave_pin_b,
  output logic o_wave_pin_b_oe
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] count_value_q;
  logic [15:0] match_value_a_q;
  logic [15:0] match_buf_a_q;
  logic [15:0] match_value_b_q;
  logic [15:0] match_buf_b_q;
  logic [15:0] capture_top_value_q;
  logic wrap_flag_q;
  logic match_flag_a_q;
  logic match_flag_b_q;
  logic capture_flag_q;
  logic wave_out_a_q;
  logic wave_out_b_q;
  logic block_q;
  logic [10:0] pre_cnt_q;

  // ----------------------------------------------------------------
  // apb decode; zero wait states, unmapped answers slverr
  // ----------------------------------------------------------------
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite;
  wire wr_ctrl = wr & (i_paddr == `TMR_OFF_CTRL);
  wire wr_count = wr & (i_paddr == `TMR_OFF_COUNT);
  wire wr_ma = wr & (i_paddr == `TMR_OFF_MATCH_A);
  wire wr_mb = wr & (i_paddr == `TMR_OFF_MATCH_B);
  wire wr_cap = wr & (i_paddr == `TMR_OFF_CAPTOP);
  wire wr_flags = wr & (i_paddr == `TMR_OFF_FLAGS);
  wire wr_force = wr & (i_paddr == `TMR_OFF_FORCE);
  wire addr_ok = (i_paddr == `TMR_OFF_CTRL) | (i_paddr == `TMR_OFF_COUNT) |
                 (i_paddr == `TMR_OFF_MATCH_A) | (i_paddr == `TMR_OFF_MATCH_B) |
                 (i_paddr == `TMR_OFF_CAPTOP) | (i_paddr == `TMR_OFF_FLAGS) |
                 (i_paddr == `TMR_OFF_FORCE) | (i_paddr == `TMR_OFF_STATUS);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [3:0] wave_gen_sel = ctrl_q[`TMR_CTRL_WGM_LSB +: 4];
  wire [2:0] pre_sel = ctrl_q[`TMR_CTRL_PRE_LSB +: 3];
  wire [1:0] out_action_sel_a = ctrl_q[`TMR_CTRL_ACT_A_LSB +: 2];
  wire [1:0] out_action_sel_b = ctrl_q[`TMR_CTRL_ACT_B_LSB +: 2];
  wire pin_dir_a = ctrl_q[`TMR_CTRL_DIR_A_BIT];
  wire pin_dir_b = ctrl_q[`TMR_CTRL_DIR_B_BIT];

  // class of a mode code; dual-slope codes are left out and stop the counter
  function automatic tmr_class_t mode_class(input logic [3:0] m);
    case (m)
      `TMR_WGM_NORMAL: mode_class = TMR_CLS_NORMAL;
      `TMR_WGM_CTC_A, `TMR_WGM_CTC_CAP: mode_class = TMR_CLS_CTC;
      `TMR_WGM_FPWM8, `TMR_WGM_FPWM9, `TMR_WGM_FPWM10,
      `TMR_WGM_FPWM_CAP, `TMR_WGM_FPWM_A: mode_class = TMR_CLS_FPWM;
      default: mode_class = TMR_CLS_OFF;
    endcase
  endfunction

  // top source; only wave_gen_sel steers counting, never the action fields
  function automatic tmr_top_src_t top_source(input logic [3:0] m);
    case (m)
      `TMR_WGM_CTC_A, `TMR_WGM_FPWM_A: top_source = TMR_TOP_MATCH_A;
      `TMR_WGM_CTC_CAP, `TMR_WGM_FPWM_CAP: top_source = TMR_TOP_CAPTURE;
      `TMR_WGM_FPWM8, `TMR_WGM_FPWM9, `TMR_WGM_FPWM10: top_source = TMR_TOP_FIXED;
      default: top_source = TMR_TOP_MAX;
    endcase
  endfunction

  wire tmr_class_t cls = mode_class(wave_gen_sel);
  wire tmr_top_src_t tsrc = top_source(wave_gen_sel);
  wire is_pwm = (cls == TMR_CLS_FPWM);

  // fixed top and its mask of live bits
  wire [15:0] fixed_top = (wave_gen_sel == `TMR_WGM_FPWM8) ? `TMR_TOP_8 :
                          (wave_gen_sel == `TMR_WGM_FPWM9) ? `TMR_TOP_9 : `TMR_TOP_10;
  wire [15:0] wr_mask = (tsrc == TMR_TOP_FIXED) ? fixed_top : `TMR_MAX;
  wire [15:0] wdata16 = i_pwdata[15:0] & wr_mask;

  // capture register used live, no shadow: a late small top is missed until wrap
  wire [15:0] top_val = (tsrc == TMR_TOP_FIXED) ? fixed_top :
                        (tsrc == TMR_TOP_MATCH_A) ? match_value_a_q :
                        (tsrc == TMR_TOP_CAPTURE) ? capture_top_value_q : `TMR_MAX;

  // ----------------------------------------------------------------
  // prescaler: select 0 stops the timer
  // ----------------------------------------------------------------
  wire [10:0] div_cnt = (pre_sel == 3'h2) ? `TMR_DIV_8 :
                        (pre_sel == 3'h3) ? `TMR_DIV_64 :
                        (pre_sel == 3'h4) ? `TMR_DIV_256 :
                        (pre_sel == 3'h5) ? `TMR_DIV_1024 : 11'h001;
  wire pre_on = (pre_sel != 3'h0) & (pre_sel <= 3'h5);
  wire tick = pre_on & (pre_cnt_q >= div_cnt - 11'h001);

  // ----------------------------------------------------------------
  // matches and counter step
  // ----------------------------------------------------------------
  wire at_top = (count_value_q == top_val);
  wire at_max = (count_value_q == `TMR_MAX);
  wire hit_a = tick & ~block_q & (count_value_q == match_value_a_q);
  wire hit_b = tick & ~block_q & (count_value_q == match_value_b_q);
  wire hit_cap = tick & ~block_q & (count_value_q == capture_top_value_q);
  wire top_hit = (tsrc == TMR_TOP_MATCH_A) ? hit_a :
                 (tsrc == TMR_TOP_CAPTURE) ? hit_cap : (tick & ~block_q & at_top);
  wire run = tick & (cls != TMR_CLS_OFF);
  // ctc clears on top match, else free-runs through max pwm likewise at top
  wire clr = run & (cls != TMR_CLS_NORMAL) & top_hit;
  wire wrap = run & at_max & ~clr;
  wire [15:0] count_d = clr ? `TMR_BOTTOM : count_value_q + 16'h0001;
  wire wrap_set = is_pwm ? clr : wrap;
  // top register flag: ctc and pwm both flag at top else plain match
  wire set_ma = hit_a & (cls != TMR_CLS_OFF);
  wire set_mb = hit_b & (cls != TMR_CLS_OFF);
  wire set_cap = hit_cap & (tsrc == TMR_TOP_CAPTURE) & (cls != TMR_CLS_OFF);
  // load buffered compares at the top clear in pwm
  wire load_buf = is_pwm & clr;

  // ----------------------------------------------------------------
  // waveform next state per channel
  // ----------------------------------------------------------------
  function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic pwm,
                                     input logic hit, input logic bottom, input logic tog_ok);
    logic r;
    r = cur;
    if (!pwm) begin
      // non-pwm: 1 toggle, 2 clear, 3 set
      case (act)
        2'h1: r = hit ? ~cur : cur;
        2'h2: r = hit ? 1'b0 : cur;
        2'h3: r = hit ? 1'b1 : cur;
        default: r = cur;
      endcase
    end else begin
      // match wins over bottom so that compare equal top gives a steady level
      case (act)
        2'h1: r = (hit & tog_ok) ? ~cur : cur;
        2'h2: r = hit ? 1'b0 : (bottom ? 1'b1 : cur);
        2'h3: r = hit ? 1'b1 : (bottom ? 1'b0 : cur);
        default: r = cur;
      endcase
    end
    wave_next = r;
  endfunction

  wire force_a = wr_force & i_pwdata[0] & ~is_pwm;
  wire force_b = wr_force & i_pwdata[1] & ~is_pwm;
  wire tog_a_ok = (wave_gen_sel == `TMR_WGM_FPWM_A);
  // both events of a cycle follow one waveform rule; force never sets a flag
  wire wave_a_d = wave_next(wave_out_a_q, out_action_sel_a, is_pwm, hit_a | force_a,
                            load_buf, tog_a_ok);
  wire wave_b_d = wave_next(wave_out_b_q, out_action_sel_b, is_pwm, hit_b | force_b,
                            load_buf, 1'b0);

  // ----------------------------------------------------------------
  // control and counter registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `TMR_CTRL_RST;
      count_value_q <= `TMR_BOTTOM;
      block_q <= 1'b0;
      pre_cnt_q <= 11'h000;
    end else begin
      if (wr_ctrl) ctrl_q <= i_pwdata;
      if (wr_count) count_value_q <= i_pwdata[15:0];
      else if (run) count_value_q <= count_d;
      // blocking lasts until the next timer tick, even while stopped
      if (wr_count) block_q <= 1'b1;
      else if (tick) block_q <= 1'b0;
      pre_cnt_q <= (!pre_on || tick) ? 11'h000 : pre_cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // compare registers: buffer written in pwm, active written directly otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_value_a_q <= `TMR_BOTTOM;
      match_buf_a_q <= `TMR_BOTTOM;
      match_value_b_q <= `TMR_BOTTOM;
      match_buf_b_q <= `TMR_BOTTOM;
      capture_top_value_q <= `TMR_BOTTOM;
    end else begin
      if (wr_ma) match_buf_a_q <= wdata16;
      if (wr_mb) match_buf_b_q <= wdata16;
      if (wr_cap) capture_top_value_q <= i_pwdata[15:0];
      if (wr_ma && !is_pwm) match_value_a_q <= wdata16;
      else if (load_buf) match_value_a_q <= match_buf_a_q;
      if (wr_mb && !is_pwm) match_value_b_q <= wdata16;
      else if (load_buf) match_value_b_q <= match_buf_b_q;
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set wins over a software write-one clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wrap_flag_q <= 1'b0;
      match_flag_a_q <= 1'b0;
      match_flag_b_q <= 1'b0;
      capture_flag_q <= 1'b0;
    end else begin
      wrap_flag_q <= wrap_set | (wrap_flag_q & ~(wr_flags & i_pwdata[`TMR_FLAG_WRAP_BIT]));
      match_flag_a_q <= set_ma | (match_flag_a_q & ~(wr_flags & i_pwdata[`TMR_FLAG_MA_BIT]));
      match_flag_b_q <= set_mb | (match_flag_b_q & ~(wr_flags & i_pwdata[`TMR_FLAG_MB_BIT]));
      capture_flag_q <= set_cap | (capture_flag_q & ~(wr_flags & i_pwdata[`TMR_FLAG_CAP_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // waveform registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_out_a_q <= 1'b0;
      wave_out_b_q <= 1'b0;
    end else begin
      wave_out_a_q <= wave_a_d;
      wave_out_b_q <= wave_b_d;
    end
  end

  // ----------------------------------------------------------------
  // pins and read data
  // ----------------------------------------------------------------
  assign o_wave_pin_a = wave_out_a_q;
  assign o_wave_pin_b = wave_out_b_q;
  assign o_wave_pin_a_oe = pin_dir_a;
  assign o_wave_pin_b_oe = pin_dir_b;
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~addr_ok;

  // match reads return what software wrote, the buffer in pwm
  wire [31:0] rd_mux =
    (i_paddr == `TMR_OFF_CTRL) ? ctrl_q :
    (i_paddr == `TMR_OFF_COUNT) ? {16'h0000, count_value_q} :
    (i_paddr == `TMR_OFF_MATCH_A) ? {16'h0000, is_pwm ? match_buf_a_q : match_value_a_q} :
    (i_paddr == `TMR_OFF_MATCH_B) ? {16'h0000, is_pwm ? match_buf_b_q : match_value_b_q} :
    (i_paddr == `TMR_OFF_CAPTOP) ? {16'h0000, capture_top_value_q} :
    (i_paddr == `TMR_OFF_FLAGS) ? {28'h0000000, capture_flag_q, match_flag_b_q,
                                   match_flag_a_q, wrap_flag_q} :
    (i_paddr == `TMR_OFF_STATUS) ? {30'h00000000, wave_out_b_q, wave_out_a_q} : 32'h0000_0000;
  assign o_prdata = (acc & ~i_pwrite) ? rd_mux : 32'h0000_0000;

endmodule

// ===== tmr_mode_engine_monitor.sv
// port checker of the timer mode engine, bound to its top module
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_mode_engine_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_wave_pin_a,
  input wire logic o_wave_pin_a_oe,
  input wire logic o_wave_pin_b,
  input wire logic o_wave_pin_b_oe
);
  logic [15:0] ctrl_q;
  logic acc, wr_ctrl, wr_force, stopped, non_pwm;
  // ----------------------------------------------------------------
  // decode of bus traffic and of the shadowed control word
  // ----------------------------------------------------------------
  assign acc = i_psel & i_penable;
  assign wr_ctrl = acc & i_pwrite & (i_paddr == `TMR_OFF_CTRL);
  assign wr_force = acc & i_pwrite & (i_paddr == `TMR_OFF_FORCE);
  assign stopped = (ctrl_q[6:4] == 3'h0) | (ctrl_q[6:5] == 2'h3);
  assign non_pwm = (ctrl_q[3:0] == 4'h0) | (ctrl_q[3:0] == 4'h4) | (ctrl_q[3:0] == 4'hC);
  // shadow control, so hold and force checks know the mode without peeking inside
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= 16'h0000;
    end else if (wr_ctrl) begin
      ctrl_q <= i_pwdata[15:0];
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // no tick can happen, so nothing but a force may move the waves
  sequence idle_s;
    stopped && !wr_force;
  endsequence
  sequence force_tog_s;
    wr_force && i_pwdata[0] && stopped && non_pwm && (ctrl_q[9:8] == 2'h1);
  endsequence
  ready_high_a:
    assert property (o_pready) else $error("ready low");
  idle_quiet_a:
    assert property (!acc |-> !o_pslverr && o_prdata == 32'h0000_0000)
    else $error("bus outputs active outside access");
  unmapped_err_a:
    assert property (acc && i_paddr > `TMR_OFF_STATUS |-> o_pslverr)
    else $error("no error on unmapped address");
  status_read_a:
    assert property (acc && !i_pwrite && i_paddr == `TMR_OFF_STATUS
      |-> o_prdata == {30'h0, o_wave_pin_b, o_wave_pin_a}) else $error("status mismatch");
  dir_follow_a:
    assert property (wr_ctrl |=> o_wave_pin_a_oe == $past(i_pwdata[12]))
    else $error("pin a enable not following control");
  oe_hold_a:
    assert property (!wr_ctrl |=> $stable(o_wave_pin_b_oe)) else $error("pin b enable moved");
  wave_hold_a:
    assert property (idle_s |=> $stable({o_wave_pin_a, o_wave_pin_b}))
    else $error("wave moved without tick");
  force_toggle_a:
    assert property (force_tog_s |=> o_wave_pin_a != $past(o_wave_pin_a))
    else $error("forced toggle missing");
  reset_low_a:
    assert property ($rose(i_rst_n) |-> !o_wave_pin_a && !o_wave_pin_b)
    else $error("wave not cleared by reset");
endmodule
bind tmr_mode_engine tmr_mode_engine_monitor tmr_mode_engine_monitor_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_wave_pin_a(o_wave_pin_a),
  .o_wave_pin_a_oe(o_wave_pin_a_oe), .o_wave_pin_b(o_wave_pin_b),
  .o_wave_pin_b_oe(o_wave_pin_b_oe));

// ===== tmr_pkg.sv
// types shared by the timer mode engine
package tmr_pkg;

  // ----------------------------------------------------------------
  // counting class of the selected waveform mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_CLS_NORMAL,
    TMR_CLS_CTC,
    TMR_CLS_FPWM,
    TMR_CLS_OFF
  } tmr_class_t;

  // top source of the selected mode
  typedef enum logic [1:0] {
    TMR_TOP_MAX,
    TMR_TOP_FIXED,
    TMR_TOP_MATCH_A,
    TMR_TOP_CAPTURE
  } tmr_top_src_t;

endpackage
